// ===== verilog/iafc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "iafc_cfg.svh"

module iafc_top #(
  parameter int unsigned SUB_CLOCK_HZ = `IAFC_SUB_CLOCK_HZ,
  parameter int unsigned PAGE_WORDS = `IAFC_PAGE_WORDS
) (
  input wire logic clk,
  input wire logic reset,
  input wire iafc_pkg::iafc_cpu_access_t cpu,
  output logic [7:0] cpu_rdata,
  output logic cpu_rvalid,
  input wire logic sub_clock_tick,
  output logic fl_req,
  output iafc_pkg::iafc_flash_cmd_t fl_cmd,
  input wire logic fl_done,
  input wire logic [15:0] fl_rdata,
  output logic chip_reset_req,
  output logic write_enabled_status
);
  import iafc_pkg::*;

  localparam int unsigned IDXW = $clog2(PAGE_WORDS);
  // Least time: round the 300 us window up to whole sub clock ticks.
  localparam int unsigned TIMEOUT_TICKS =
    (`IAFC_TIMEOUT_US * SUB_CLOCK_HZ + 999999) / 1000000;
  localparam int unsigned TO_TICKS = (TIMEOUT_TICKS < 1) ? 1 : TIMEOUT_TICKS;

  // Register state.
  iafc_mode_t operation_mode_field;
  logic write_procedure_enable;
  logic write_start;
  logic read_enable;
  logic read_start;
  logic buffer_clear_start;
  logic [7:0] chip_reset_trigger;
  logic [14:0] flash_address;
  logic [7:0] data_low [4];
  logic [7:0] data_high [4];
  logic [15:0] write_buffer [PAGE_WORDS];

  // Sequencer state.
  iafc_state_t state;
  logic [IDXW-1:0] seq_idx;
  logic timeout_overflow;

  // True when the current core access is a write to the given offset.
  function automatic logic reg_write(input iafc_cpu_access_t acc, input logic [7:0] ofs);
    reg_write = acc.wr && (acc.sector == `IAFC_SECTOR) && (acc.addr == ofs);
  endfunction

  // Address decode of the block.
  wire in_block = (cpu.sector == `IAFC_SECTOR) && (cpu.addr >= `IAFC_OFS_CONTROL)
    && (cpu.addr <= `IAFC_OFS_DATA3_HIGH);
  wire wr_control = reg_write(cpu, `IAFC_OFS_CONTROL);
  wire wr_chip_reset = reg_write(cpu, `IAFC_OFS_CHIP_RESET);
  wire wr_buf_clear = reg_write(cpu, `IAFC_OFS_BUF_CLEAR);
  wire wr_addr_low = reg_write(cpu, `IAFC_OFS_ADDR_LOW);
  wire wr_addr_high = reg_write(cpu, `IAFC_OFS_ADDR_HIGH);
  wire wr_data0_high = reg_write(cpu, `IAFC_OFS_DATA0_HIGH);
  wire wr_data3_high = reg_write(cpu, `IAFC_OFS_DATA3_HIGH);
  wire [1:0] data_sel = 2'((cpu.addr - `IAFC_OFS_DATA0_LOW) >> 1);
  wire data_is_high = cpu.addr[0];
  wire wr_data = cpu.wr && in_block && (cpu.addr >= `IAFC_OFS_DATA0_LOW);

  // Control register write fields.
  wire [2:0] wr_mode = cpu.wdata[`IAFC_MODE_MSB:`IAFC_MODE_LSB];
  wire sw_clear_enabled = wr_control && !cpu.wdata[`IAFC_BIT_WR_ENABLED];
  wire sw_set_write = wr_control && cpu.wdata[`IAFC_BIT_WR_START];
  wire sw_set_read = wr_control && cpu.wdata[`IAFC_BIT_RD_START];
  wire sw_set_clear = wr_buf_clear && cpu.wdata[`IAFC_BIT_CLEAR_START];

  // Enable procedure: armed while the procedure bit is set in enable mode.
  wire proc_armed = write_procedure_enable && (operation_mode_field == MODE_WREN);
  wire pattern_ok = proc_armed && !timeout_overflow
    && (data_low[1] == `IAFC_PAT0) && (data_high[1] == `IAFC_PAT1)
    && (data_low[2] == `IAFC_PAT2) && (data_high[2] == `IAFC_PAT3)
    && (data_low[3] == `IAFC_PAT4) && (cpu.wdata == `IAFC_PAT5);
  wire enable_success = wr_data3_high && pattern_ok;

  // Sequencer start decisions, taken only from idle.
  wire idle = (state == ST_IDLE);
  wire start_clear = idle && buffer_clear_start;
  wire start_write = idle && !buffer_clear_start && write_start
    && write_enabled_status && (operation_mode_field == MODE_WRITE);
  wire start_erase = idle && !buffer_clear_start && write_start
    && write_enabled_status && (operation_mode_field == MODE_ERASE);
  wire reject_write = idle && !buffer_clear_start && write_start
    && !start_write && !start_erase;
  wire start_read = idle && !buffer_clear_start && !write_start && read_start
    && read_enable && (operation_mode_field == MODE_READ);
  wire reject_read = idle && !buffer_clear_start && !write_start && read_start
    && !start_read;
  wire last_idx = (seq_idx == IDXW'(PAGE_WORDS - 1));
  wire write_finish = (state == ST_WRITE) && fl_done && last_idx;
  wire erase_finish = (state == ST_ERASE) && fl_done;
  wire read_finish = (state == ST_READ) && fl_done;
  wire clear_finish = (state == ST_CLEAR) && last_idx;

  // Hardware clears of the self-clearing request bits.
  wire hw_clr_write = write_finish || erase_finish || reject_write;
  wire hw_clr_read = read_finish || reject_read;
  wire hw_clr_clear = clear_finish;
  wire [14:0] page_base = {flash_address[14:IDXW], IDXW'(0)};

  // Time-out counter for the enable window.
  iafc_timeout #(
    .TICKS(TO_TICKS)
  ) u_timeout (
    .clk(clk),
    .reset(reset),
    .arm(proc_armed),
    .sub_tick(sub_clock_tick),
    .overflow(timeout_overflow)
  );

  // Mode, procedure and read-enable bits; software owns them except the time-out clear.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      operation_mode_field <= MODE_WRITE;
      write_procedure_enable <= 1'b0;
      read_enable <= 1'b0;
    end
    else if (wr_control)
    begin
      operation_mode_field <= iafc_mode_t'(wr_mode);
      write_procedure_enable <= cpu.wdata[`IAFC_BIT_PROC_EN];
      read_enable <= cpu.wdata[`IAFC_BIT_RD_ENABLE];
    end
    else if (timeout_overflow)
      write_procedure_enable <= 1'b0;
  end

  // Status and request bits: a set always beats a clear in the same cycle.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      write_enabled_status <= 1'b0;
      write_start <= 1'b0;
      read_start <= 1'b0;
      buffer_clear_start <= 1'b0;
    end
    else
    begin
      write_enabled_status <= enable_success || (write_enabled_status && !sw_clear_enabled);
      write_start <= sw_set_write || (write_start && !hw_clr_write);
      read_start <= sw_set_read || (read_start && !hw_clr_read);
      buffer_clear_start <= sw_set_clear || (buffer_clear_start && !hw_clr_clear);
    end
  end

  // Chip reset register; the reset request is a one-cycle pulse.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      chip_reset_trigger <= `IAFC_RESET_BYTE;
      chip_reset_req <= 1'b0;
    end
    else
    begin
      if (wr_chip_reset)
        chip_reset_trigger <= cpu.wdata;
      chip_reset_req <= wr_chip_reset && (cpu.wdata == `IAFC_CHIP_RESET_KEY);
    end
  end

  // Flash address; the high byte only keeps seven bits.
  always_ff @(posedge clk)
  begin
    if (reset)
      flash_address <= 15'h0000;
    else if (wr_addr_low)
      flash_address[7:0] <= cpu.wdata;
    else if (wr_addr_high)
      flash_address[14:8] <= cpu.wdata[6:0];
    else if (wr_data0_high)
      flash_address <= flash_address + 15'h0001;
  end

  // Data word registers; a finished read lands in the first word.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < 4; i++)
      begin
        data_low[i] <= `IAFC_RESET_BYTE;
        data_high[i] <= `IAFC_RESET_BYTE;
      end
    end
    else if (read_finish)
    begin
      data_low[0] <= fl_rdata[7:0];
      data_high[0] <= fl_rdata[15:8];
    end
    else if (wr_data && data_is_high)
      data_high[data_sel] <= cpu.wdata;
    else if (wr_data)
      data_low[data_sel] <= cpu.wdata;
  end

  // Write buffer: filled by the first word's high byte, wiped one word per cycle.
  // It has no reset on purpose, so it can map onto a plain RAM.
  always_ff @(posedge clk)
  begin
    if (state == ST_CLEAR)
      write_buffer[seq_idx] <= 16'h0000;
    else if (wr_data0_high)
      write_buffer[flash_address[IDXW-1:0]] <= {cpu.wdata, data_low[0]};
  end

  // Sequencer. The write streams the whole page, one handshake per word.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      seq_idx <= '0;
      fl_cmd <= '0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          seq_idx <= '0;
          if (start_clear)
            state <= ST_CLEAR;
          else if (start_write)
          begin
            state <= ST_WRITE;
            fl_cmd <= '{op: OP_WRITE, addr: page_base, wdata: write_buffer[0]};
          end
          else if (start_erase)
          begin
            state <= ST_ERASE;
            fl_cmd <= '{op: OP_ERASE, addr: page_base, wdata: 16'h0000};
          end
          else if (start_read)
          begin
            state <= ST_READ;
            fl_cmd <= '{op: OP_READ, addr: flash_address, wdata: 16'h0000};
          end
        end
        ST_CLEAR:
        begin
          seq_idx <= seq_idx + 1'b1;
          if (last_idx)
            state <= ST_IDLE;
        end
        ST_WRITE:
        begin
          if (fl_done && last_idx)
            state <= ST_IDLE;
          else if (fl_done)
          begin
            seq_idx <= seq_idx + 1'b1;
            fl_cmd.addr <= page_base | 15'(seq_idx + 1'b1);
            fl_cmd.wdata <= write_buffer[seq_idx + 1'b1];
          end
        end
        ST_ERASE, ST_READ:
        begin
          if (fl_done)
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // The array request stands while a flash operation waits for its done pulse.
  assign fl_req = (state == ST_WRITE) || (state == ST_ERASE) || (state == ST_READ);

  // Read-back value of the addressed register.
  logic [7:0] next_rdata;
  always_comb
  begin
    next_rdata = 8'h00;
    if (in_block)
    begin
      unique case (cpu.addr)
        `IAFC_OFS_CONTROL:
          next_rdata = {write_enabled_status, operation_mode_field, write_procedure_enable,
                        write_start, read_enable, read_start};
        `IAFC_OFS_CHIP_RESET: next_rdata = chip_reset_trigger;
        `IAFC_OFS_BUF_CLEAR: next_rdata = {7'h00, buffer_clear_start};
        `IAFC_OFS_ADDR_LOW: next_rdata = flash_address[7:0];
        `IAFC_OFS_ADDR_HIGH: next_rdata = {1'b0, flash_address[14:8]};
        default: next_rdata = data_is_high ? data_high[data_sel] : data_low[data_sel];
      endcase
    end
  end

  // Read data is registered, so it appears the cycle after the read strobe.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cpu_rdata <= 8'h00;
      cpu_rvalid <= 1'b0;
    end
    else
    begin
      cpu_rvalid <= cpu.rd;
      if (cpu.rd)
        cpu_rdata <= next_rdata;
    end
  end

endmodule // iafc_top
`default_nettype wire

// ===== inc/iafc_cfg.svh
// Overview of operation
// - Registers live in data memory sector 1, offsets 43H to 4FH; pointer high byte 01H.
// - Write-enabled status set only by hardware; software 0 clears it, 1 does nothing.
// - Mode field bits 6:4: 000 write, 001 page erase, 011 read, 110 enable mode.
// - Procedure bit set with mode 110 runs the write-enable procedure.
// - Procedure bit set by software only; hardware clears it on 300us time-out overflow.
// - Write-start bit starts a flash write; hardware clears it when the write completes.
// - Read-enable bit at 1 allows flash reads; at 0 reads are blocked.
// - Read-start bit starts a flash read; hardware clears it when the read completes.
// - Writing 55H to the chip reset register resets the chip; otherwise plain storage.
// - Buffer-clear bit starts clearing the write buffer; hardware clears it when done.
// - Bits 7 to 1 of the buffer-clear register read as zero.
// - Flash address is 15 bits: low register bits 7:0, high register bits 14:8.
// - Writing the first word low byte only stores it, nothing enters the buffer.
// - Writing the first word high byte loads 16 bits into the buffer, address plus one.
// - Second and third data words are plain 16-bit read/write pairs resetting to zero.
// - Pattern 00,04,0D,09,C3,40 into words one to three within 300us enables writing.
// - Page erase covers 64 words selected by address bits 14:6; bits 5:0 ignored.
`ifndef IAFC_CFG_SVH
`define IAFC_CFG_SVH

// Data memory placement of the register block.
`define IAFC_SECTOR 8'h01
`define IAFC_OFS_CONTROL 8'h43
`define IAFC_OFS_CHIP_RESET 8'h44
`define IAFC_OFS_BUF_CLEAR 8'h45
`define IAFC_OFS_ADDR_LOW 8'h46
`define IAFC_OFS_ADDR_HIGH 8'h47
`define IAFC_OFS_DATA0_LOW 8'h48
`define IAFC_OFS_DATA0_HIGH 8'h49
`define IAFC_OFS_DATA1_LOW 8'h4a
`define IAFC_OFS_DATA1_HIGH 8'h4b
`define IAFC_OFS_DATA2_LOW 8'h4c
`define IAFC_OFS_DATA2_HIGH 8'h4d
`define IAFC_OFS_DATA3_LOW 8'h4e
`define IAFC_OFS_DATA3_HIGH 8'h4f

// Field positions of the control register.
`define IAFC_BIT_WR_ENABLED 7
`define IAFC_MODE_MSB 6
`define IAFC_MODE_LSB 4
`define IAFC_BIT_PROC_EN 3
`define IAFC_BIT_WR_START 2
`define IAFC_BIT_RD_ENABLE 1
`define IAFC_BIT_RD_START 0
`define IAFC_BIT_CLEAR_START 0

// Reset values and magic values.
`define IAFC_RESET_BYTE 8'h00
`define IAFC_CHIP_RESET_KEY 8'h55
`define IAFC_PAT0 8'h00
`define IAFC_PAT1 8'h04
`define IAFC_PAT2 8'h0d
`define IAFC_PAT3 8'h09
`define IAFC_PAT4 8'hc3
`define IAFC_PAT5 8'h40

// Page size and enable time-out.
`define IAFC_PAGE_WORDS 64
`define IAFC_TIMEOUT_US 300
`define IAFC_SUB_CLOCK_HZ 32000

`endif

// ===== inc/iafc_pkg.sv
package iafc_pkg;

  // Operation mode field codes.
  typedef enum logic [2:0]
  {
    MODE_WRITE = 3'b000,
    MODE_ERASE = 3'b001,
    MODE_RSV2 = 3'b010,
    MODE_READ = 3'b011,
    MODE_RSV4 = 3'b100,
    MODE_RSV5 = 3'b101,
    MODE_WREN = 3'b110,
    MODE_RSV7 = 3'b111
  } iafc_mode_t;

  // Flash sequencer states.
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_CLEAR = 3'b001,
    ST_WRITE = 3'b010,
    ST_ERASE = 3'b011,
    ST_READ = 3'b100
  } iafc_state_t;

  // Flash array operations.
  typedef enum logic [1:0]
  {
    OP_WRITE = 2'b00,
    OP_ERASE = 2'b01,
    OP_READ = 2'b10
  } iafc_op_t;

  // One data memory access from the core.
  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [7:0] sector;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iafc_cpu_access_t;

  // One command towards the flash array.
  typedef struct packed
  {
    iafc_op_t op;
    logic [14:0] addr;
    logic [15:0] wdata;
  } iafc_flash_cmd_t;

endpackage

// ===== verilog/iafc_timeout.sv
`timescale 1ns/1ns
`default_nettype none
`include "iafc_cfg.svh"

module iafc_timeout #(
  parameter int unsigned TICKS = 10
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic arm,
  input wire logic sub_tick,
  output logic overflow
);
  import iafc_pkg::*;

  logic [15:0] count;
  logic expired;
  wire last_tick = sub_tick && (count == 16'(TICKS - 1));

  // Counts sub clock ticks while armed; one pulse at the end, then waits for disarm.
  always_ff @(posedge clk)
  begin
    if (reset || !arm)
    begin
      count <= 16'h0000;
      expired <= 1'b0;
    end
    else if (!expired && sub_tick)
    begin
      count <= last_tick ? 16'h0000 : count + 16'h0001;
      expired <= last_tick;
    end
  end

  // Pulse is registered so it lines up with the rest of the control logic.
  always_ff @(posedge clk)
  begin
    if (reset)
      overflow <= 1'b0;
    else
      overflow <= arm && !expired && last_tick;
  end

endmodule // iafc_timeout
`default_nettype wire

// ===== sim/iafc_props.sv
`timescale 1ns/1ns
`default_nettype none
module iafc_props
(
  input wire logic clk,
  input wire logic reset,
  input wire iafc_pkg::iafc_cpu_access_t cpu,
  input wire logic [7:0] cpu_rdata,
  input wire logic cpu_rvalid,
  input wire logic fl_req,
  input wire iafc_pkg::iafc_flash_cmd_t fl_cmd,
  input wire logic fl_done,
  input wire logic chip_reset_req,
  input wire logic write_enabled_status
);
  import iafc_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Accesses that land in the register sector.
  wire sec_wr = cpu.wr && cpu.sector == 8'h01;
  wire sec_rd = cpu.rd && cpu.sector == 8'h01;
  wire key_wr = sec_wr && cpu.addr == 8'h44 && cpu.wdata == 8'h55;

  rd_answer_a: assert property (cpu.rd |=> cpu_rvalid)
    else $error("read gave no answer");
  rd_cause_a: assert property (cpu_rvalid |-> $past(cpu.rd))
    else $error("answer without read");
  chip_reset_a: assert property (key_wr |=> chip_reset_req)
    else $error("key write gave no chip reset");
  reset_cause_a: assert property (chip_reset_req |-> $past(key_wr))
    else $error("chip reset without key write");
  req_hold_a: assert property (fl_req && !fl_done |=> fl_req && $stable(fl_cmd))
    else $error("flash request dropped or changed early");
  status_clear_a: assert property (sec_wr && cpu.addr == 8'h43 && !cpu.wdata[7]
    |=> !write_enabled_status)
    else $error("status survived a clearing write");
  status_set_a: assert property ($rose(write_enabled_status)
    |-> $past(sec_wr && cpu.addr == 8'h4f && cpu.wdata == 8'h40))
    else $error("status rose without final pattern byte");
  write_gate_a: assert property (fl_req && fl_cmd.op != OP_READ |-> write_enabled_status)
    else $error("write or erase while not enabled");
  erase_page_a: assert property (fl_req && fl_cmd.op == OP_ERASE
    |-> fl_cmd.addr[5:0] == 6'h00)
    else $error("erase address not page aligned");
  clear_bits_a: assert property (sec_rd && cpu.addr == 8'h45 |=> cpu_rdata[7:1] == 7'h00)
    else $error("buffer clear upper bits not zero");

  // Main flows seen at least once.
  cover property (fl_req && fl_done && fl_cmd.op == OP_WRITE);
  cover property (fl_req && fl_done && fl_cmd.op == OP_ERASE);
  cover property ($rose(write_enabled_status));
endmodule // iafc_props
`default_nettype wire

// ===== sim/iafc_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module iafc_flash_model
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [1:0] lat,
  input wire logic fl_req,
  input wire iafc_pkg::iafc_flash_cmd_t fl_cmd,
  output logic fl_done,
  output logic [15:0] fl_rdata
);
  import iafc_pkg::*;
  logic [15:0] mem [0:32767];
  logic [1:0] cnt;
  // Answers after lat waiting cycles; read data toggles outside an answer so stale data shows.
  always @(posedge clk)
  begin
    fl_done <= 1'b0;
    fl_rdata <= ~fl_rdata;
    if (reset)
    begin
      cnt <= 2'd0;
      fl_rdata <= 16'h5a5a;
    end
    else if (fl_req && !fl_done)
    begin
      cnt <= cnt + 2'd1;
      if (cnt >= lat)
      begin
        cnt <= 2'd0;
        fl_done <= 1'b1;
        if (fl_cmd.op == OP_WRITE)
          mem[fl_cmd.addr] <= fl_cmd.wdata;
        if (fl_cmd.op == OP_READ)
          fl_rdata <= mem[fl_cmd.addr];
        if (fl_cmd.op == OP_ERASE)
          for (int i = 0; i < 64; i++)
            mem[{fl_cmd.addr[14:6], i[5:0]}] <= 16'hffff;
      end
    end
  end
endmodule // iafc_flash_model
`default_nettype wire

// ===== sim/tb_iap_flash_access_control.sv
`timescale 1ns/1ns
`default_nettype none
module tb_iap_flash_access_control;
  import iafc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  iafc_cpu_access_t cpu = '0;
  logic tick = 1'b0;
  logic [1:0] lat = 2'd1;
  logic [7:0] cpu_rdata;
  logic cpu_rvalid;
  logic fl_req;
  logic fl_done;
  logic chip_reset_req;
  logic write_enabled_status;
  logic [15:0] fl_rdata;
  iafc_flash_cmd_t fl_cmd;
  iafc_flash_cmd_t none_cmd = '1;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 32'h9731;
  logic [7:0] rq[$];
  iafc_flash_cmd_t cq[$];
  logic rst_q[$];
  logic [15:0] buf_w [0:63];
  logic [14:0] pg;
  logic [7:0] pat [0:5] = '{8'h00, 8'h04, 8'h0d, 8'h09, 8'hc3, 8'h40};
  always #2 clk = ~clk;
  iafc_top i_dut (.clk(clk), .reset(reset), .cpu(cpu), .cpu_rdata(cpu_rdata),
    .cpu_rvalid(cpu_rvalid), .sub_clock_tick(tick), .fl_req(fl_req), .fl_cmd(fl_cmd),
    .fl_done(fl_done), .fl_rdata(fl_rdata), .chip_reset_req(chip_reset_req),
    .write_enabled_status(write_enabled_status));
  iafc_flash_model i_mem (.clk(clk), .reset(reset), .lat(lat), .fl_req(fl_req),
    .fl_cmd(fl_cmd), .fl_done(fl_done), .fl_rdata(fl_rdata));

  task automatic tally_and_finish();
    if (num_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk_byte(logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] cpu_rdata expected %h seen %h", e, g);
    end
  endtask

  // Single-bit results and leftover notes; an unknown value counts as a mismatch.
  task automatic chk_pulse(string n, logic e, logic g);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask

  // Only writes carry meaningful data, so other commands compare op and address.
  task automatic chk_cmd(iafc_flash_cmd_t e, iafc_flash_cmd_t g);
    compares++;
    if (e.op !== OP_WRITE)
      g.wdata = e.wdata;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] fl_cmd expected %h seen %h", e, g);
    end
  endtask

  // One bus access per cycle; the next call replaces it, idle releases it.
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d, logic [7:0] s);
    cpu <= '{wr: w, rd: !w, sector: s, addr: a, wdata: d};
    @(posedge clk);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d, logic [7:0] s = 8'h01);
    acc(1'b1, a, d, s);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    rq.push_back(e);
    acc(1'b0, a, 8'h00, 8'h01);
  endtask
  task automatic idle(int n);
    cpu <= '0;
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_idle();
    idle(3);
    for (int i = 0; i < 3000 && fl_req !== 1'b0; i++)
      @(posedge clk);
    idle(2);
  endtask
  task automatic ticks(int n);
    idle(1);
    repeat (n)
    begin
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  task automatic pattern(logic [7:0] last);
    for (int i = 0; i < 6; i++)
      wr(8'h4a + i[7:0], (i == 5) ? last : pat[i]);
  endtask
  task automatic set_addr(logic [14:0] a);
    wr(8'h46, a[7:0]);
    wr(8'h47, {1'b0, a[14:8]});
  endtask

  // Results are checked in arrival order against the notes queued by the driver.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      num_errors++;
      tally_and_finish();
    end
    if (cpu_rvalid === 1'b1)
      chk_byte(rq.pop_front(), cpu_rdata);
    if (fl_req === 1'b1 && fl_done === 1'b1)
      chk_cmd(cq.size() > 0 ? cq.pop_front() : none_cmd, fl_cmd);
    if (chip_reset_req !== 1'b0)
      chk_pulse("chip_reset_req", (rst_q.size() > 0) ? rst_q.pop_front() : 1'b0, chip_reset_req);
  end

  initial
  begin
    logic [7:0] d;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (int a = 8'h43; a <= 8'h50; a++)
      rd(a[7:0], 8'h00);
    wr(8'h46, 8'hff, 8'h00);
    rd(8'h46, 8'h00);
    for (int a = 8'h4a; a <= 8'h4d; a++)
    begin
      d = $random(seed);
      wr(a[7:0], d);
      rd(a[7:0], d);
    end
    wr(8'h47, 8'hff);
    rd(8'h47, 8'h7f);
    wr(8'h45, 8'hfe);
    rd(8'h45, 8'h00);
    wr(8'h44, 8'h5a);
    rd(8'h44, 8'h5a);
    rst_q.push_back(1'b1);
    wr(8'h44, 8'h55);
    rd(8'h44, 8'h55);
    // A wrong pattern, then a time-out, must both leave writing disabled.
    wr(8'h43, 8'h68);
    pattern(8'h41);
    rd(8'h43, 8'h68);
    wr(8'h43, 8'h68);
    ticks(12);
    rd(8'h43, 8'h60);
    pattern(8'h40);
    rd(8'h43, 8'h60);
    wr(8'h43, 8'h68);
    pattern(8'h40);
    rd(8'h43, 8'he8);
    // Erase a page from an unaligned address.
    pg = $random(seed);
    pg[5:0] = 6'h2b;
    lat <= $random(seed);
    cq.push_back('{OP_ERASE, {pg[14:6], 6'h00}, 16'h0000});
    set_addr(pg);
    wr(8'h43, 8'h94);
    wait_idle();
    rd(8'h43, 8'h90);
    pg[5:0] = 6'h00;
    wr(8'h45, 8'h01);
    rd(8'h45, 8'h01);
    idle(70);
    rd(8'h45, 8'h00);
    // Load the buffer; a stale low byte after each load must not reach it.
    set_addr(pg);
    for (int i = 0; i < 64; i++)
    begin
      buf_w[i] = $random(seed);
      wr(8'h48, buf_w[i][7:0]);
      wr(8'h49, buf_w[i][15:8]);
      wr(8'h48, ~buf_w[i][7:0]);
      cq.push_back('{OP_WRITE, {pg[14:6], i[5:0]}, buf_w[i]});
    end
    rd(8'h46, pg[7:0] + 8'h40);
    rd(8'h47, {1'b0, pg[14:8] + 7'(pg[7:6] == 2'b11)});
    set_addr(pg);
    lat <= $random(seed);
    wr(8'h43, 8'h84);
    wait_idle();
    rd(8'h43, 8'h80);
    cq.push_back('{OP_READ, {pg[14:6], 6'h25}, 16'h0000});
    set_addr({pg[14:6], 6'h25});
    wr(8'h43, 8'hb3);
    wait_idle();
    rd(8'h48, buf_w[37][7:0]);
    rd(8'h49, buf_w[37][15:8]);
    rd(8'h43, 8'hb2);
    // Refused starts: read disabled, reserved modes, writing not enabled.
    wr(8'h43, 8'hb1);
    idle(3);
    rd(8'h43, 8'hb0);
    for (int m = 2; m < 8; m++)
      if (m != 3 && m != 6)
      begin
        wr(8'h43, {1'b1, m[2:0], 4'h4});
        idle(3);
        rd(8'h43, {1'b1, m[2:0], 4'h0});
      end
    wr(8'h43, 8'h04);
    idle(3);
    rd(8'h43, 8'h00);
    wr(8'h43, 8'h80);
    rd(8'h43, 8'h00);
    idle(4);
    // A note still queued means a read answer, flash command or chip reset never came.
    chk_pulse("pending notes", 1'b0, (cq.size() + rq.size() + rst_q.size()) != 0);
    tally_and_finish();
  end
endmodule // tb_iap_flash_access_control

bind iafc_top iafc_props i_props (.clk(clk), .reset(reset), .cpu(cpu),
  .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .fl_req(fl_req), .fl_cmd(fl_cmd),
  .fl_done(fl_done), .chip_reset_req(chip_reset_req),
  .write_enabled_status(write_enabled_status));
`default_nettype wire
